// ==== fls_consts.vh ====
`ifndef FLS_CONSTS_VH
`define FLS_CONSTS_VH

// register offsets on the plain register port
`define FLS_ADDR_SCS 4'h0
`define FLS_ADDR_STAT 4'h1
`define FLS_SCS_RESET 8'h00

// store_control_status field positions
`define FLS_BIT_IRQ_EN 7
`define FLS_BIT_SECTION_BUSY 6
`define FLS_BIT_REENABLE 4
`define FLS_BIT_LOCK_SEL 3
`define FLS_BIT_PAGE_WRITE 2
`define FLS_BIT_PAGE_ERASE 1
`define FLS_BIT_STORE_EN 0

// status register field positions
`define FLS_BIT_EE_BUSY 0
`define FLS_BIT_FLASH_BUSY 1

// readback selectors held in the address pointer
`define FLS_SEL_FUSE_LOW 16'h0000
`define FLS_SEL_LOCK 16'h0001
`define FLS_SEL_FUSE_EXT 16'h0002
`define FLS_SEL_FUSE_HIGH 16'h0003

// arm windows in cycles after the control write
`define FLS_LOAD_WINDOW 3'h3
`define FLS_STORE_WINDOW 3'h4

// flash write duration, in microseconds, and clock rate
`define FLS_T_WRITE_MIN_US 3700
`define FLS_T_WRITE_MAX_US 4500
`define FLS_T_WRITE_US 4100
`define FLS_CLK_MHZ 125

// first word of the halting section, page size in words
`define FLS_HALT_START_WORD 15'h3800
`define FLS_PAGE_WORDS 64

`endif

// ==== fls_core_model.sv ====
`timescale 1ns/1ps
module fls_core_model (
    input wire [15:0] load_addr,
    output wire [7:0] flash_byte
);
    // memory image: a hash keeps each byte apart from the fuse values
    assign flash_byte = load_addr[7:0] ^ 8'ha5;
endmodule // fls_core_model

// ==== fls_fuse_mux.v ====
`timescale 1ns/1ps
`include "fls_consts.vh"

module fls_fuse_mux (
    input wire [15:0] pointer,
    input wire [7:0] fuse_low_byte,
    input wire [7:0] fuse_high_byte,
    input wire [7:0] fuse_extended_byte,
    input wire [7:0] lock_bits,
    output reg [7:0] value
);

// bits pass unchanged: 0 means programmed, 1 means unprogrammed
always @*
begin
    case (pointer)
        `FLS_SEL_FUSE_LOW: value = fuse_low_byte; // R04 R07
        `FLS_SEL_LOCK: value = lock_bits; // R01 R07
        `FLS_SEL_FUSE_EXT: value = fuse_extended_byte; // R06
        `FLS_SEL_FUSE_HIGH: value = fuse_high_byte; // R05
        default: value = 8'hff; // R19
    endcase
end

endmodule // fls_fuse_mux

// ==== fls_spm_chk.sv ====
`timescale 1ns/1ps
module fls_spm_chk (
    input wire clock,
    input wire reset,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire [7:0] reg_rdata,
    input wire load_req,
    input wire [15:0] load_addr,
    input wire [7:0] flash_byte,
    input wire [7:0] load_data,
    input wire load_valid,
    input wire store_req,
    input wire fetch_req,
    input wire [15:0] fetch_addr,
    input wire fetch_stall,
    input wire eeprom_write_busy,
    input wire [7:0] fuse_low_byte,
    input wire [7:0] lock_bits,
    input wire flash_erase,
    input wire flash_write,
    input wire section_busy_flag,
    input wire cpu_halt
);
////////////////////////////////////////
// cycles since the last accepted arming write, saturating at 7
reg [2:0] since_arm;
wire ctl_wr = reg_wr && reg_addr == 4'h0 && !eeprom_write_busy;
always @(posedge clock)
    if (reset)
        since_arm <= 3'h7;
    else if (ctl_wr && reg_wdata[0])
        since_arm <= 3'h1;
    else if (since_arm != 3'h7)
        since_arm <= since_arm + 3'h1;
default clocking cb @(posedge clock);
endclocking
default disable iff (reset);
// only arm writes made while neither cpu_halt nor section_busy_flag is set; a running lock bit write is not excluded
sequence arm_rb;
    ctl_wr && reg_wdata == 8'h09 && !cpu_halt && !section_busy_flag;
endsequence
////////////////////////////////////////
a_load_answer: assert property (load_req |=> load_valid)
    else $error("load got no answer");
a_lock_readback: assert property (arm_rb ##1 load_req && load_addr == 16'h0001
    |=> load_data == $past(lock_bits)) else $error("lock readback wrong");
a_fuse_low: assert property (arm_rb ##1 load_req && load_addr == 16'h0000
    |=> load_data == $past(fuse_low_byte)) else $error("fuse low readback wrong");
a_unarmed_load: assert property (load_req && since_arm > 3'h3
    |=> load_data == $past(flash_byte)) else $error("normal load substituted");
a_erase_start: assert property (ctl_wr && reg_wdata == 8'h03 && !cpu_halt
    && !section_busy_flag ##1 store_req |=> flash_erase) else $error("erase not started");
a_late_store: assert property (ctl_wr && reg_wdata == 8'h03
    ##1 (!reg_wr && !store_req)[*4] ##1 store_req |=> !flash_erase)
    else $error("store taken after window");
a_halt_stall: assert property (cpu_halt && fetch_req |=> fetch_stall)
    else $error("fetch served while halted");
a_busy_stall: assert property (section_busy_flag && fetch_req
    && fetch_addr[15:11] == 5'h00 |=> fetch_stall) else $error("busy section fetched");
a_reset_quiet: assert property (disable iff (1'b0) reset
    |=> !load_valid && !flash_erase && !flash_write && reg_rdata == 8'h00)
    else $error("activity out of reset");
c_readback: cover property (arm_rb ##1 load_req);
c_page_write: cover property (flash_write);
c_halt_fetch: cover property (cpu_halt && fetch_req);
endmodule // fls_spm_chk

bind fls_spm_ctrl fls_spm_chk u_chk (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .load_req(load_req), .load_addr(load_addr),
    .flash_byte(flash_byte), .load_data(load_data), .load_valid(load_valid),
    .store_req(store_req), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_stall(fetch_stall), .eeprom_write_busy(eeprom_write_busy),
    .fuse_low_byte(fuse_low_byte), .lock_bits(lock_bits), .flash_erase(flash_erase),
    .flash_write(flash_write), .section_busy_flag(section_busy_flag), .cpu_halt(cpu_halt)
);

// ==== fls_spm_ctrl.v ====
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "fls_consts.vh"

// How it works
// R01 - pointer 1, armed load returns lock bits
// R02 - arm bits clear after readback or timeout
// R03 - unarmed load reads program memory normally
// R04 - pointer 0 returns fuse low byte
// R05 - pointer 3 returns fuse high byte
// R06 - pointer 2 returns extended fuse byte
// R07 - programmed bits read 0, unprogrammed 1
// R08 - reset never aborts a running write
// R09 - write lasts 3.7 to 4.5 ms
// R10 - core polls store enable before new command
// R11 - core waits for eeprom idle first
// R12 - core masks interrupts around timed sequence
// R13 - core erases, loads, writes, re-enables page
// R14 - core re-enables until section busy clears
// R15 - during programming fetch only halting section
// R16 - control register bit layout as given
// R17 - section busy set on start, cleared later
// R18 - re-enable during load discards page buffer
// R19 - unknown selectors read all ones, read-only
// R20 - reset clears arm bits and pending arm
module fls_spm_ctrl #(
    parameter TICK_DIV = `FLS_CLK_MHZ,
    parameter WRITE_TICKS = `FLS_T_WRITE_US,
    parameter PAGE_WORDS = `FLS_PAGE_WORDS
) (
    input wire clock,
    input wire reset,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire load_req,
    input wire [15:0] load_addr,
    input wire [7:0] flash_byte,
    output reg [7:0] load_data,
    output reg load_valid,
    input wire store_req,
    input wire [15:0] store_addr,
    input wire [15:0] store_data,
    input wire fetch_req,
    input wire [15:0] fetch_addr,
    output reg fetch_stall,
    input wire eeprom_write_busy,
    input wire [7:0] fuse_low_byte,
    input wire [7:0] fuse_high_byte,
    input wire [7:0] fuse_extended_byte,
    input wire [7:0] lock_bits,
    output reg flash_erase,
    output reg flash_write,
    output reg flash_lock,
    output reg [14-$clog2(PAGE_WORDS):0] flash_page,
    output reg [7:0] lock_data,
    input wire [$clog2(PAGE_WORDS)-1:0] buf_rd_index,
    output reg [15:0] buf_rd_data,
    output reg section_busy_flag,
    output reg cpu_halt
);

localparam PB = $clog2(PAGE_WORDS);

////////////////////////////////////////////////////////////////////////////////
// store_control_status and arm state

reg store_irq_enable;
reg section_reenable;
reg lock_read_select;
reg page_write_cmd;
reg page_erase_cmd;
reg store_enable;
reg [2:0] arm_cnt;
reg op_was_write;
reg [15:0] page_buf [0:PAGE_WORDS-1];
reg [PAGE_WORDS-1:0] loaded;

wire op_busy;
wire op_done;
wire [7:0] fuse_value;
wire armed;
wire [2:0] window_last;
wire readback_hit;
wire store_hit;
wire timed_op;
wire page_load;
wire in_concurrent;
wire scs_wr;
wire scs_rd;
wire [7:0] scs_value;
wire [PB-1:0] word_idx;

// once a timed write runs, store_enable stays high until it is done or reset clears it, so the
// arm counter and the windows only apply to an idle flash
// the done cycle still shows store_enable high; it must not take a new store
assign armed = store_enable && !op_busy && !op_done;
assign window_last = lock_read_select ? `FLS_LOAD_WINDOW - 3'h1 : `FLS_STORE_WINDOW - 3'h1;

// an eeprom write in flight also blocks fuse and lock readback
assign readback_hit = load_req && armed && lock_read_select && !eeprom_write_busy
    && (arm_cnt < `FLS_LOAD_WINDOW); // R01
assign store_hit = store_req && armed && (arm_cnt < `FLS_STORE_WINDOW);
assign timed_op = store_hit && (page_erase_cmd || page_write_cmd || lock_read_select);
assign page_load = store_hit && !page_erase_cmd && !page_write_cmd && !lock_read_select
    && !section_reenable;
assign in_concurrent = store_addr[15:1] < `FLS_HALT_START_WORD;
assign word_idx = store_addr[PB:1];

// control writes are dropped while the eeprom is writing
assign scs_wr = reg_wr && (reg_addr == `FLS_ADDR_SCS) && !eeprom_write_busy;
assign scs_rd = reg_rd && (reg_addr == `FLS_ADDR_SCS);

assign scs_value = {store_irq_enable, section_busy_flag, 1'b0, section_reenable,
    lock_read_select, page_write_cmd, page_erase_cmd, store_enable}; // R16

////////////////////////////////////////////////////////////////////////////////
// write timing and readback selection

fls_timer #(
    .TICK_DIV(TICK_DIV),
    .WRITE_TICKS(WRITE_TICKS)
) u_timer (
    .clock(clock),
    .reset(reset),
    .start(timed_op),
    .busy(op_busy),
    .done(op_done)
);

fls_fuse_mux u_fuse_mux (
    .pointer(load_addr),
    .fuse_low_byte(fuse_low_byte),
    .fuse_high_byte(fuse_high_byte),
    .fuse_extended_byte(fuse_extended_byte),
    .lock_bits(lock_bits),
    .value(fuse_value)
);

////////////////////////////////////////////////////////////////////////////////
// control register, commands and load answers

always @(posedge clock)
begin
    if (reset)
    begin
        store_irq_enable <= 1'b0;
        section_reenable <= 1'b0;
        lock_read_select <= 1'b0; // R20
        page_write_cmd <= 1'b0;
        page_erase_cmd <= 1'b0;
        store_enable <= 1'b0; // R20
        arm_cnt <= 3'h0; // R20
        section_busy_flag <= 1'b0;
        // a write that outlives reset keeps the core halted until it ends
        cpu_halt <= cpu_halt && op_busy; // R08
        op_was_write <= op_was_write && op_busy;
        load_data <= 8'h00;
        load_valid <= 1'b0;
        flash_erase <= 1'b0;
        flash_write <= 1'b0;
        flash_lock <= 1'b0;
        flash_page <= {(15-PB){1'b0}};
        lock_data <= 8'hff;
    end
    else
    begin
        load_valid <= load_req;
        flash_erase <= 1'b0;
        flash_write <= 1'b0;
        flash_lock <= 1'b0;
        if (load_req)
        begin
            if (readback_hit)
                load_data <= fuse_value; // R01 R19
            else
                load_data <= flash_byte; // R03
        end
        if (armed)
            arm_cnt <= arm_cnt + 3'h1;
        if (op_done)
        begin
            // completion clears the command; the poll on store_enable sees it
            store_enable <= 1'b0;
            page_erase_cmd <= 1'b0;
            page_write_cmd <= 1'b0;
            lock_read_select <= 1'b0;
            cpu_halt <= 1'b0;
            op_was_write <= 1'b0;
        end
        if (readback_hit)
        begin
            lock_read_select <= 1'b0; // R02
            store_enable <= 1'b0; // R02
        end
        else if (store_hit)
        begin
            if (page_erase_cmd || page_write_cmd)
            begin
                flash_erase <= page_erase_cmd;
                flash_write <= page_write_cmd;
                flash_page <= store_addr[15:PB+1];
                op_was_write <= page_write_cmd;
                if (in_concurrent)
                    section_busy_flag <= 1'b1; // R17
                else
                    cpu_halt <= 1'b1; // R15
            end
            else if (lock_read_select)
            begin
                flash_lock <= 1'b1;
                lock_data <= store_data[7:0];
            end
            else
            begin
                // re-enable or page load: both finish at once and free the
                // concurrent section
                section_busy_flag <= 1'b0; // R17
                section_reenable <= 1'b0;
                store_enable <= 1'b0;
            end
        end
        else if (armed && arm_cnt == window_last)
        begin
            lock_read_select <= 1'b0; // R02
            store_enable <= 1'b0; // R02
            page_erase_cmd <= 1'b0;
            page_write_cmd <= 1'b0;
            section_reenable <= 1'b0;
        end
        if (scs_wr)
        begin
            store_irq_enable <= reg_wdata[`FLS_BIT_IRQ_EN];
            // command bits are frozen while a timed write runs
            if (!op_busy && !timed_op)
            begin
                store_enable <= reg_wdata[`FLS_BIT_STORE_EN]; // R16
                page_erase_cmd <= reg_wdata[`FLS_BIT_PAGE_ERASE] && reg_wdata[`FLS_BIT_STORE_EN];
                page_write_cmd <= reg_wdata[`FLS_BIT_PAGE_WRITE] && reg_wdata[`FLS_BIT_STORE_EN];
                lock_read_select <= reg_wdata[`FLS_BIT_LOCK_SEL] && reg_wdata[`FLS_BIT_STORE_EN];
                section_reenable <= reg_wdata[`FLS_BIT_REENABLE] && reg_wdata[`FLS_BIT_STORE_EN];
                arm_cnt <= 3'h0;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// temporary page buffer

// each word takes one load only; a second load to the same word is ignored
// until the buffer is erased
always @(posedge clock)
begin
    if (reset)
        loaded <= {PAGE_WORDS{1'b0}};
    else if (scs_wr && reg_wdata[`FLS_BIT_REENABLE] && !op_busy)
        loaded <= {PAGE_WORDS{1'b0}}; // R18
    else if (op_done && op_was_write)
        loaded <= {PAGE_WORDS{1'b0}};
    else if (page_load && !loaded[word_idx])
        loaded[word_idx] <= 1'b1;
end

always @(posedge clock)
begin
    if (page_load && !loaded[word_idx])
        page_buf[word_idx] <= store_data;
end

// words never loaded read as erased flash
always @(posedge clock)
begin
    if (reset)
        buf_rd_data <= 16'hffff;
    else if (loaded[buf_rd_index])
        buf_rd_data <= page_buf[buf_rd_index];
    else
        buf_rd_data <= 16'hffff;
end

////////////////////////////////////////////////////////////////////////////////
// fetch guard: the concurrent section cannot be fetched while it is busy

always @(posedge clock)
begin
    if (reset)
        fetch_stall <= 1'b0;
    else
        fetch_stall <= fetch_req && (cpu_halt
            || (section_busy_flag && fetch_addr[15:1] < `FLS_HALT_START_WORD)); // R15
end

////////////////////////////////////////////////////////////////////////////////
// register read port, data in the cycle after the strobe

always @(posedge clock)
begin
    if (reset)
        reg_rdata <= 8'h00;
    else if (scs_rd)
        reg_rdata <= scs_value;
    else if (reg_rd && reg_addr == `FLS_ADDR_STAT)
        reg_rdata <= {6'h00, op_busy, eeprom_write_busy};
    else
        reg_rdata <= 8'h00;
end

endmodule // fls_spm_ctrl

// ==== fls_timer.v ====
`timescale 1ns/1ps
`include "fls_consts.vh"

module fls_timer #(
    parameter TICK_DIV = `FLS_CLK_MHZ,
    parameter WRITE_TICKS = `FLS_T_WRITE_US
) (
    input wire clock,
    input wire reset,
    input wire start,
    output reg busy = 1'b0,
    output reg done
);

localparam PW = $clog2(TICK_DIV + 1);
localparam TW = $clog2(WRITE_TICKS + 1);
localparam [PW-1:0] PRE_LAST = TICK_DIV - 1;
localparam [TW-1:0] TICK_LAST = WRITE_TICKS - 1;

reg [PW-1:0] prescale;
reg us_tick;
reg [TW-1:0] ticks;

////////////////////////////////////////////////////////////////////////////////
// a running write ignores reset: aborting it would leave the page half done
always @(posedge clock)
begin
    if (reset && !busy)
    begin
        prescale <= {PW{1'b0}};
        ticks <= {TW{1'b0}};
        us_tick <= 1'b0;
        done <= 1'b0;
    end
    else
    begin
        done <= 1'b0;
        us_tick <= 1'b0;
        if (start && !busy)
        begin
            busy <= 1'b1;
            prescale <= {PW{1'b0}};
            ticks <= {TW{1'b0}};
        end
        else if (busy)
        begin
            // one-microsecond enable stands in for the calibrated oscillator
            if (prescale == PRE_LAST)
            begin
                prescale <= {PW{1'b0}};
                us_tick <= 1'b1;
            end
            else
                prescale <= prescale + 1'b1;
            if (us_tick)
            begin
                if (ticks == TICK_LAST)
                begin
                    busy <= 1'b0; // R09
                    done <= 1'b1;
                end
                else
                    ticks <= ticks + 1'b1;
            end
        end
    end
end

endmodule // fls_timer

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
localparam [7:0] f_lo = 8'h62;
localparam [7:0] f_hi = 8'hd9;
localparam [7:0] f_ex = 8'hfd;
localparam [7:0] lk = 8'h3c;
reg clock = 1'b0;
reg reset = 1'b1;
reg [3:0] reg_addr = 4'h0;
reg [7:0] reg_wdata = 8'h00;
reg reg_wr = 1'b0;
reg reg_rd = 1'b0;
reg load_req = 1'b0;
reg [15:0] load_addr = 16'h0000;
reg store_req = 1'b0;
reg [15:0] store_addr = 16'h0000;
reg [15:0] store_data = 16'h0000;
reg fetch_req = 1'b0;
reg [15:0] fetch_addr = 16'h0000;
reg ee_busy = 1'b0;
reg [5:0] buf_idx = 6'h00;
wire [7:0] reg_rdata, flash_byte, load_data;
wire [15:0] buf_data;
wire load_valid, fetch_stall, flash_erase, flash_write, busy, halt, lock_pulse;
wire [7:0] lock_val;
wire [8:0] page_no;
reg lockp;
integer fail_count = 0;
integer checked = 0;
integer cycles = 0;
reg [7:0] rdv;
reg [1:0] pulses;
reg stall;
fls_core_model core (.load_addr(load_addr), .flash_byte(flash_byte));
// short timed writes: 5 ticks of 2 cycles stand for the full duration
fls_spm_ctrl #(.TICK_DIV(2), .WRITE_TICKS(5)) DUT (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .load_req(load_req),
    .load_addr(load_addr), .flash_byte(flash_byte), .load_data(load_data),
    .load_valid(load_valid), .store_req(store_req), .store_addr(store_addr),
    .store_data(store_data), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_stall(fetch_stall), .eeprom_write_busy(ee_busy), .fuse_low_byte(f_lo),
    .fuse_high_byte(f_hi), .fuse_extended_byte(f_ex), .lock_bits(lk),
    .flash_erase(flash_erase), .flash_write(flash_write), .flash_lock(lock_pulse),
    .flash_page(page_no), .lock_data(lock_val), .buf_rd_index(buf_idx),
    .buf_rd_data(buf_data),
    .section_busy_flag(busy), .cpu_halt(halt)
);
initial forever #4 clock = ~clock;
////////////////////////////////////////
task chk(input bit ok, input string m);
    checked = checked + 1;
    if (!ok)
    begin
        fail_count = fail_count + 1;
        $display("unexpected at %0t: %s", $time, m);
    end
endtask
task end_of_test;
    if (fail_count == 0 && checked > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
always @(posedge clock)
begin
    cycles = cycles + 1;
    if (cycles == 4000)
    begin
        chk(1'b0, "timeout");
        end_of_test;
    end
end
// every bus task ends one edge after its strobe drops, so strobes never re-rise in one step
task wr(input [3:0] a, input [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
endtask
task rd(input [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rdv = reg_rdata;
    @(posedge clock);
endtask
task ld(input [15:0] a, input [7:0] e);
    load_addr <= a;
    load_req <= 1'b1;
    @(posedge clock);
    load_req <= 1'b0;
    @(negedge clock);
    chk(load_valid === 1'b1 && load_data === e, "load result");
    @(posedge clock);
endtask
task st(input [15:0] a, input [15:0] d);
    store_addr <= a;
    store_data <= d;
    store_req <= 1'b1;
    @(posedge clock);
    store_req <= 1'b0;
    @(negedge clock);
    pulses = {flash_erase, flash_write};
    lockp = lock_pulse;
    @(posedge clock);
endtask
task fet(input [15:0] a);
    fetch_addr <= a;
    fetch_req <= 1'b1;
    @(posedge clock);
    fetch_req <= 1'b0;
    @(negedge clock);
    stall = fetch_stall;
    @(posedge clock);
endtask
task bufchk(input [5:0] i, input [15:0] e);
    buf_idx <= i;
    @(posedge clock);
    @(negedge clock);
    chk(buf_data === e, "page buffer word");
    @(posedge clock);
endtask
task poll(input [3:0] a, input integer b);
    integer n;
    rdv = 8'hff;
    for (n = 0; n < 60 && rdv[b]; n = n + 1)
        rd(a);
    chk(rdv[b] === 1'b0, "busy never cleared");
endtask
// control write and store go back to back, as with interrupts masked
task spm(input [7:0] c, input [15:0] a, input [15:0] d);
    poll(4'h0, 0);
    poll(4'h1, 0);
    wr(4'h0, c);
    st(a, d);
endtask
////////////////////////////////////////
task t_regs;
    wr(4'h0, 8'h80);
    rd(4'h0);
    chk(rdv === 8'h80, "irq enable bit");
    wr(4'h0, 8'h00);
    rd(4'h5);
    chk(rdv === 8'h00, "unmapped read");
endtask
task t_readback;
    integer i;
    reg [7:0] e;
    for (i = 0; i < 5; i = i + 1)
    begin
        e = i == 0 ? f_lo : i == 1 ? lk : i == 2 ? f_ex : i == 3 ? f_hi : 8'hff;
        wr(4'h0, 8'h09);
        ld(i[15:0], e);
    end
    rd(4'h0);
    chk(rdv === 8'h00, "arm left set");
endtask
task t_expiry;
    wr(4'h0, 8'h09);
    rd(4'h0);
    chk(rdv === 8'h09, "armed readback bits");
    ld(16'h0001, 8'h01 ^ 8'ha5);
    wr(4'h0, 8'h09);
    @(posedge clock);
    ld(16'h0001, lk);
    ee_busy <= 1'b1;
    rd(4'h1);
    chk(rdv === 8'h01, "eeprom busy status");
    wr(4'h0, 8'h09);
    ld(16'h0001, 8'h01 ^ 8'ha5);
    ee_busy <= 1'b0;
    wr(4'h0, 8'h03);
    repeat (3) @(posedge clock);
    st(16'h0100, 16'h0000);
    chk(pulses === 2'b00, "late store taken");
endtask
task t_page;
    integer i;
    spm(8'h03, 16'h0100, 16'h0000);
    chk(pulses === 2'b10 && busy === 1'b1, "erase start");
    fet(16'h0010);
    chk(stall === 1'b1, "fetch while busy");
    spm(8'h11, 16'h0100, 16'h0000);
    chk(busy === 1'b0, "reenable");
    for (i = 0; i < 3; i = i + 1)
        spm(8'h01, 16'h0100 + {i[14:0], 1'b0}, 16'hc0de + i[15:0]);
    bufchk(6'h02, 16'hc0e0);
    spm(8'h11, 16'h0100, 16'h0000);
    bufchk(6'h02, 16'hffff);
    spm(8'h01, 16'h0100, 16'h1234);
    spm(8'h05, 16'h0100, 16'h0000);
    chk(pulses === 2'b01 && busy === 1'b1, "page write start");
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(4'h1);
    chk(rdv[1] === 1'b1, "write aborted by reset");
    poll(4'h1, 1);
    rd(4'h0);
    chk(rdv === 8'h00, "control after reset");
    bufchk(6'h00, 16'hffff);
    ld(16'h0001, 8'h01 ^ 8'ha5);
endtask
task t_halt;
    integer n;
    spm(8'h03, 16'h7000, 16'h0000);
    chk(halt === 1'b1, "halting erase");
    chk(page_no === 9'h0e0, "erase page");
    fet(16'h0010);
    chk(stall === 1'b1, "fetch while halted");
    for (n = 2; n < 40 && halt === 1'b1; n = n + 1)
        @(negedge clock);
    chk(n >= 9 && n < 20, "write duration");
    fet(16'h0010);
    chk(stall === 1'b0, "fetch after halt");
endtask
task t_lock;
    spm(8'h09, 16'h0001, 16'h00c3);
    chk(lockp === 1'b1 && lock_val === 8'hc3, "lock write start");
    poll(4'h0, 0);
    chk(halt === 1'b0 && busy === 1'b0, "lock write flags");
endtask
initial
begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    t_regs;
    t_readback;
    t_expiry;
    t_page;
    t_halt;
    t_lock;
    end_of_test;
end
endmodule // tb
